// *** cse_consts.vh ***
`ifndef CSE_CONSTS_VH
`define CSE_CONSTS_VH

// ==========================================================================
// function count and address layout
`define CSE_NUM_PF            4
`define CSE_ADDR_W            12
`define CSE_FUNC_BLOCK_END    12'h0100
`define CSE_ADDR_FUNC_PRESENT 12'h0100
`define CSE_ADDR_STATUS       12'h0104
`define CSE_FUNC_PRESENT_RST  3'h4

// ==========================================================================
// register index inside one function block (byte offset = index * 4)
`define CSE_IDX_ROUTE         3'h0
`define CSE_IDX_COMMAND       3'h1
`define CSE_IDX_SRIOV_CTRL    3'h2
`define CSE_IDX_VF_COUNT      3'h3
`define CSE_IDX_DEV_CTRL      3'h4
`define CSE_IDX_DEV_CTRL2     3'h5
`define CSE_IDX_HINT_CTRL     3'h6
`define CSE_IDX_XLATE_CTRL    3'h7

// ==========================================================================
// writable bit masks per register
`define CSE_MASK_ROUTE        16'h1fff
`define CSE_MASK_COMMAND      16'h0006
`define CSE_MASK_SRIOV_CTRL   16'h0008
`define CSE_MASK_VF_COUNT     16'hffff
`define CSE_MASK_DEV_CTRL     16'h71e0
`define CSE_MASK_DEV_CTRL2    16'h0050
`define CSE_MASK_HINT_CTRL    16'h0103
`define CSE_MASK_XLATE_CTRL   16'h801f

// ==========================================================================
// reset values (read request limit resets to code 2)
`define CSE_RST_DEV_CTRL      16'h2000
`define CSE_RST_OTHER         16'h0000

// ==========================================================================
// field positions
`define CSE_BUS_LSB           0
`define CSE_DEV_LSB           8
`define CSE_MEM_BIT           1
`define CSE_MASTER_BIT        2
`define CSE_VFMEM_BIT         3
`define CSE_MPS_LSB           5
`define CSE_WIDETAG_BIT       8
`define CSE_MRRS_LSB          12
`define CSE_CPLOFF_BIT        4
`define CSE_ATOMIC_BIT        6
`define CSE_STMODE_LSB        0
`define CSE_HINTEN_BIT        8
`define CSE_STU_LSB           0
`define CSE_XLATEEN_BIT       15

// ==========================================================================
// timing: edges from committing write to changed export
`define CSE_EXPORT_LATENCY    2

`endif

// *** cse_func_regs.v ***
`timescale 1ns/100ps
`include "cse_consts.vh"

// ==========================================================================
// one physical function's configuration fields
module cse_func_regs (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        wr_en,
  input  wire [2:0]  wr_index,
  input  wire [31:0] wr_data,
  input  wire [2:0]  rd_index,
  output wire [31:0] rd_data,
  output wire [7:0]  bus_number,
  output wire [4:0]  device_number,
  output wire        memory_on,
  output wire        master_on,
  output wire        vf_memory_on,
  output wire [15:0] vf_count,
  output wire [2:0]  payload_code,
  output wire [2:0]  read_req_code,
  output wire        wide_tag_on,
  output wire        cpl_timer_off,
  output wire        atomic_on,
  output wire [1:0]  st_mode,
  output wire        hint_on,
  output wire [4:0]  stu,
  output wire        xlate_on
);

  reg [15:0] regs_q [0:7];
  integer    i;

  // writable bits of each register; the rest stay zero
  function [15:0] wmask;
    input [2:0] idx;
    begin
      case (idx)
        `CSE_IDX_ROUTE:      wmask = `CSE_MASK_ROUTE;
        `CSE_IDX_COMMAND:    wmask = `CSE_MASK_COMMAND;
        `CSE_IDX_SRIOV_CTRL: wmask = `CSE_MASK_SRIOV_CTRL;
        `CSE_IDX_VF_COUNT:   wmask = `CSE_MASK_VF_COUNT;
        `CSE_IDX_DEV_CTRL:   wmask = `CSE_MASK_DEV_CTRL;
        `CSE_IDX_DEV_CTRL2:  wmask = `CSE_MASK_DEV_CTRL2;
        `CSE_IDX_HINT_CTRL:  wmask = `CSE_MASK_HINT_CTRL;
        default:             wmask = `CSE_MASK_XLATE_CTRL;
      endcase
    end
  endfunction

  // register store, masked write
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 8; i = i + 1) begin
        regs_q[i] <= (i == 4) ? `CSE_RST_DEV_CTRL : `CSE_RST_OTHER;
      end
    end else if (wr_en) begin
      regs_q[wr_index] <= wr_data[15:0] & wmask(wr_index);
    end
  end

  // read path and field taps
  assign rd_data       = {16'h0000, regs_q[rd_index]};
  assign bus_number    = regs_q[0][`CSE_BUS_LSB +: 8];
  assign device_number = regs_q[0][`CSE_DEV_LSB +: 5];
  assign memory_on     = regs_q[1][`CSE_MEM_BIT];
  assign master_on     = regs_q[1][`CSE_MASTER_BIT];
  assign vf_memory_on  = regs_q[2][`CSE_VFMEM_BIT];
  assign vf_count      = regs_q[3];
  assign payload_code  = regs_q[4][`CSE_MPS_LSB +: 3];
  assign read_req_code = regs_q[4][`CSE_MRRS_LSB +: 3];
  assign wide_tag_on   = regs_q[4][`CSE_WIDETAG_BIT];
  assign cpl_timer_off = regs_q[5][`CSE_CPLOFF_BIT];
  assign atomic_on     = regs_q[5][`CSE_ATOMIC_BIT];
  assign st_mode       = regs_q[6][`CSE_STMODE_LSB +: 2];
  assign hint_on       = regs_q[6][`CSE_HINTEN_BIT];
  assign stu           = regs_q[7][`CSE_STU_LSB +: 5];
  assign xlate_on      = regs_q[7][`CSE_XLATEEN_BIT];

endmodule

// *** cse_min_code.v ***
`timescale 1ns/100ps
`include "cse_consts.vh"

// ==========================================================================
// smallest 3-bit code among the present functions
module cse_min_code (
  input  wire [11:0] codes,
  input  wire [2:0]  present,
  output reg  [2:0]  min_code
);

  integer i;

  // function 0 always counts; others only while present
  always @* begin
    min_code = codes[2:0];
    for (i = 1; i < `CSE_NUM_PF; i = i + 1) begin
      if ((i < present) && (codes[3*i +: 3] < min_code)) begin
        min_code = codes[3*i +: 3];
      end
    end
  end

endmodule

// *** cse_config_export.v ***
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "cse_consts.vh"

module cse_config_export (
  input  wire        clock,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // exported configuration
  output reg  [31:0] func_bus_number,
  output reg  [19:0] func_device_number,
  output reg  [3:0]  pf_memory_decode_on,
  output reg  [3:0]  pf_requester_allowed,
  output reg  [3:0]  vf_memory_decode_on,
  output reg  [63:0] pf_vf_count,
  output reg  [2:0]  link_payload_limit,
  output reg  [2:0]  link_read_request_limit,
  output reg  [3:0]  pf_wide_tag_on,
  output reg  [3:0]  pf_cpl_timer_off,
  output reg  [3:0]  pf_atomic_issue_on,
  output reg  [7:0]  pf_steering_tag_mode,
  output reg  [3:0]  pf_hint_requester_on,
  output reg  [19:0] pf_translation_unit_size,
  output reg  [3:0]  pf_translation_service_on
);

  // ========================================================================
  // access decode
  wire        setup_phase;
  wire        write_commit;
  wire        in_func_block;
  wire [1:0]  func_sel;
  wire [3:0]  reg_index;
  wire        func_hit;
  wire        present_hit;
  wire        status_hit;
  wire        addr_hit;

  // setup cycle loads the answer; access edge commits writes
  assign setup_phase   = psel & ~penable;
  assign write_commit  = psel & penable & pready & pwrite;
  assign in_func_block = (paddr < `CSE_FUNC_BLOCK_END);
  assign func_sel      = paddr[7:6];
  assign reg_index     = paddr[5:2];
  assign func_hit      = in_func_block & ~reg_index[3] & (paddr[1:0] == 2'h0);
  assign present_hit   = (paddr == `CSE_ADDR_FUNC_PRESENT);
  assign status_hit    = (paddr == `CSE_ADDR_STATUS);
  assign addr_hit      = func_hit | present_hit | status_hit;

  // ========================================================================
  // function count control, steers the limit reduction
  reg  [2:0]  func_present_q;
  wire        present_ok;

  // only counts of 1 through NUM_PF are accepted
  assign present_ok = (pwdata[2:0] != 3'h0) && (pwdata[31:3] == 29'h0000_0000)
                      && (pwdata[2:0] <= `CSE_NUM_PF);

  // software-written function count
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      func_present_q <= `CSE_FUNC_PRESENT_RST;
    end else if (write_commit && present_hit && present_ok) begin
      func_present_q <= pwdata[2:0];
    end
  end

  // ========================================================================
  // per function register sets
  wire [127:0] func_rd_data;
  wire [31:0]  bus_number_w;
  wire [19:0]  device_number_w;
  wire [3:0]   memory_on_w;
  wire [3:0]   master_on_w;
  wire [3:0]   vf_memory_on_w;
  wire [63:0]  vf_count_w;
  wire [11:0]  payload_code_w;
  wire [11:0]  read_req_code_w;
  wire [3:0]   wide_tag_w;
  wire [3:0]   cpl_off_w;
  wire [3:0]   atomic_w;
  wire [7:0]   st_mode_w;
  wire [3:0]   hint_on_w;
  wire [19:0]  stu_w;
  wire [3:0]   xlate_on_w;

  genvar f;
  generate
    for (f = 0; f < `CSE_NUM_PF; f = f + 1) begin : g_func
      // configuration write lands in the selected function only
      cse_func_regs u_regs (
        .clock         (clock),
        .reset_n       (reset_n),
        .wr_en         (write_commit & func_hit & (func_sel == f)),
        .wr_index      (reg_index[2:0]),
        .wr_data       (pwdata),
        .rd_index      (reg_index[2:0]),
        .rd_data       (func_rd_data[32*f +: 32]),
        .bus_number    (bus_number_w[8*f +: 8]),
        .device_number (device_number_w[5*f +: 5]),
        .memory_on     (memory_on_w[f]),
        .master_on     (master_on_w[f]),
        .vf_memory_on  (vf_memory_on_w[f]),
        .vf_count      (vf_count_w[16*f +: 16]),
        .payload_code  (payload_code_w[3*f +: 3]),
        .read_req_code (read_req_code_w[3*f +: 3]),
        .wide_tag_on   (wide_tag_w[f]),
        .cpl_timer_off (cpl_off_w[f]),
        .atomic_on     (atomic_w[f]),
        .st_mode       (st_mode_w[2*f +: 2]),
        .hint_on       (hint_on_w[f]),
        .stu           (stu_w[5*f +: 5]),
        .xlate_on      (xlate_on_w[f])
      );
    end
  endgenerate

  // ========================================================================
  // link-wide limits: minimum across present functions
  wire [2:0] payload_min_w;
  wire [2:0] read_req_min_w;

  // payload limit reduction
  cse_min_code u_payload_min (
    .codes    (payload_code_w),
    .present  (func_present_q),
    .min_code (payload_min_w)
  );

  // read request limit reduction
  cse_min_code u_read_req_min (
    .codes    (read_req_code_w),
    .present  (func_present_q),
    .min_code (read_req_min_w)
  );

  // ========================================================================
  // export stage: every output from a flop on the application clock
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      func_bus_number           <= 32'h0000_0000;
      func_device_number        <= 20'h0_0000;
      pf_memory_decode_on       <= 4'h0;
      pf_requester_allowed      <= 4'h0;
      vf_memory_decode_on       <= 4'h0;
      pf_vf_count               <= 64'h0000_0000_0000_0000;
      link_payload_limit        <= 3'h0;
      link_read_request_limit   <= 3'h2;
      pf_wide_tag_on            <= 4'h0;
      pf_cpl_timer_off          <= 4'h0;
      pf_atomic_issue_on        <= 4'h0;
      pf_steering_tag_mode      <= 8'h00;
      pf_hint_requester_on      <= 4'h0;
      pf_translation_unit_size  <= 20'h0_0000;
      pf_translation_service_on <= 4'h0;
    end else begin
      // one edge behind the store, so a write shows two edges later
      func_bus_number           <= bus_number_w;
      func_device_number        <= device_number_w;
      pf_memory_decode_on       <= memory_on_w;
      pf_requester_allowed      <= master_on_w;
      vf_memory_decode_on       <= vf_memory_on_w;
      pf_vf_count               <= vf_count_w;
      link_payload_limit        <= payload_min_w;
      link_read_request_limit   <= read_req_min_w;
      pf_wide_tag_on            <= wide_tag_w;
      pf_cpl_timer_off          <= cpl_off_w;
      pf_atomic_issue_on        <= atomic_w;
      pf_steering_tag_mode      <= st_mode_w;
      pf_hint_requester_on      <= hint_on_w;
      pf_translation_unit_size  <= stu_w;
      pf_translation_service_on <= xlate_on_w;
    end
  end

  // ========================================================================
  // read data select
  reg [31:0] rd_mux;

  // status shows the limits currently exported and the function count
  always @* begin
    if (func_hit) begin
      rd_mux = func_rd_data[32*func_sel +: 32];
    end else if (present_hit) begin
      rd_mux = {29'h0000_0000, func_present_q};
    end else if (status_hit) begin
      rd_mux = {21'h00_0000, link_read_request_limit, 1'b0, link_payload_limit,
                1'b0, func_present_q};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // ========================================================================
  // apb answer: one wait-free access cycle, loaded at the setup edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~addr_hit | (pwrite & status_hit);  // status is read-only
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// *** cse_config_export_props.sv ***
`timescale 1ns/100ps

// ==========================================================================
// concurrent checks on the apb slave and the exported configuration
module cse_config_export_props (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] func_bus_number,
  input wire logic [3:0]  pf_memory_decode_on,
  input wire logic [63:0] pf_vf_count,
  input wire logic [2:0]  link_payload_limit,
  input wire logic [2:0]  link_read_request_limit,
  input wire logic [7:0]  pf_steering_tag_mode,
  input wire logic [19:0] pf_translation_unit_size
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // a committed write; exports may only move shortly after one
  logic wr_c;
  assign wr_c = psel & penable & pready & pwrite;

  ready_after_setup_a: assert property (psel && !penable |=> pready && psel && penable)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  bus_hold_a: assert property ($changed(func_bus_number) |-> $past(wr_c, 1) || $past(wr_c, 2))
    else $error("bus number moved without a write");
  mem_hold_a: assert property ($changed(pf_memory_decode_on) |-> $past(wr_c, 1) || $past(wr_c, 2))
    else $error("memory enable moved without a write");
  vf_hold_a: assert property ($changed(pf_vf_count) |-> $past(wr_c, 1) || $past(wr_c, 2))
    else $error("vf count moved without a write");
  tag_hold_a: assert property ($changed(pf_steering_tag_mode) || $changed(pf_translation_unit_size)
    |-> $past(wr_c, 1) || $past(wr_c, 2))
    else $error("hint or translation field moved without a write");
  status_limit_a: assert property (pready && !pwrite && paddr == 12'h104
    |-> prdata[6:4] == link_payload_limit && prdata[10:8] == link_read_request_limit)
    else $error("status limits differ from exported limits");
  hole_error_a: assert property (pready && paddr < 12'h100 && paddr[5] |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
endmodule

bind cse_config_export cse_config_export_props u_cse_config_export_props (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .func_bus_number(func_bus_number),
  .pf_memory_decode_on(pf_memory_decode_on), .pf_vf_count(pf_vf_count), .link_payload_limit(link_payload_limit),
  .link_read_request_limit(link_read_request_limit), .pf_steering_tag_mode(pf_steering_tag_mode),
  .pf_translation_unit_size(pf_translation_unit_size)
);

// *** cse_app_model.sv ***
`timescale 1ns/100ps

// ==========================================================================
// application logic: builds its requester id from the exported numbers
module cse_app_model (
  input  wire logic [31:0] func_bus_number,
  input  wire logic [19:0] func_device_number,
  input  wire logic [3:0]  pf_requester_allowed,
  input  wire logic        ari_on,
  input  wire logic [1:0]  sel_func,
  output logic      [15:0] req_id,
  output logic             req_ok
);
  logic [7:0] bus_sel;
  logic [4:0] dev_sel;

  // exported numbers only inform the id; the core fills real headers itself
  assign bus_sel = func_bus_number[8*sel_func +: 8];
  assign dev_sel = func_device_number[5*sel_func +: 5];
  // with ari the device number is ignored and the function fills the low byte
  assign req_id  = ari_on ? {bus_sel, 6'h00, sel_func} : {bus_sel, dev_sel, 1'b0, sel_func};
  assign req_ok  = pf_requester_allowed[sel_func];
endmodule

// *** tb_cse_config_export.sv ***
`timescale 1ns/100ps
`include "cse_consts.vh"

module tb_cse_config_export;
  logic clock, reset_n, psel, penable, pwrite, ari_on, er, pm_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, func_bus_number;
  logic        pready, pslverr, req_ok;
  logic [19:0] func_device_number, pf_translation_unit_size, e_dev, e_stu;
  logic [3:0]  pf_memory_decode_on, pf_requester_allowed, vf_memory_decode_on, pf_wide_tag_on, pf_cpl_timer_off;
  logic [3:0]  pf_atomic_issue_on, pf_hint_requester_on, pf_translation_service_on;
  logic [3:0]  e_mem, e_mst, e_vfm, e_wt, e_cpl, e_at, e_hen, e_xen;
  logic [63:0] pf_vf_count, e_vfc;
  logic [2:0]  link_payload_limit, link_read_request_limit, pm, rm;
  logic [7:0]  pf_steering_tag_mode, e_st;
  logic [31:0] e_bus, cfg [4][8];
  logic [15:0] req_id;
  logic [1:0]  sel_func;
  int          err_total, n_checks;
  logic [11:0] bad_a [4] = '{12'h020, 12'h108, 12'h104, 12'h0fc};

  cse_config_export u_cse_config_export (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .func_bus_number(func_bus_number),
    .func_device_number(func_device_number), .pf_memory_decode_on(pf_memory_decode_on),
    .pf_requester_allowed(pf_requester_allowed), .vf_memory_decode_on(vf_memory_decode_on),
    .pf_vf_count(pf_vf_count), .link_payload_limit(link_payload_limit),
    .link_read_request_limit(link_read_request_limit), .pf_wide_tag_on(pf_wide_tag_on),
    .pf_cpl_timer_off(pf_cpl_timer_off), .pf_atomic_issue_on(pf_atomic_issue_on),
    .pf_steering_tag_mode(pf_steering_tag_mode), .pf_hint_requester_on(pf_hint_requester_on),
    .pf_translation_unit_size(pf_translation_unit_size), .pf_translation_service_on(pf_translation_service_on));

  cse_app_model u_cse_app_model (
    .func_bus_number(func_bus_number), .func_device_number(func_device_number),
    .pf_requester_allowed(pf_requester_allowed), .ari_on(ari_on), .sel_func(sel_func), .req_id(req_id),
    .req_ok(req_ok));

  // ==========================================================================
  // clock, watchdog and shared tasks
  always #2 clock = ~clock;

  initial begin
    #(4 * 20000);
    err_total++;
    print_verdict();
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // per-function write pattern, every multi-bit field differs between functions
  function automatic logic [31:0] pat(input int f, input int i);
    logic [7:0] b;
    logic [4:0] d;
    b = 8'(8'h81 + 8'h22 * f);
    d = 5'(5'h11 + 3 * f);
    case (i)
      0: pat = 32'hffff_e000 | {19'h0, d, b};
      1: pat = {29'h0, ~f[0], f[0], 1'b0};
      2: pat = {28'h0, f[1], 3'h0};
      3: pat = {16'h0, 16'(16'h1234 * (f + 1))};
      4: pat = {17'h0, 3'(6 - f), 3'h0, ~f[0], 3'(5 - f), 5'h0};
      5: pat = {25'h0, f[0], 1'b0, f[1], 4'h0};
      6: pat = {23'h0, ~f[1], 6'h0, 2'(f)};
      default: pat = {16'h0, f[0], 10'h0, 5'(3 + 7 * f)};
    endcase
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    clock = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ari_on = 0; sel_func = 0; err_total = 0; n_checks = 0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk("rd_limit_rst", link_read_request_limit, 3'h2);
    chk("bus_rst", func_bus_number, 32'h0000_0000);
    apb(`CSE_ADDR_STATUS, 1'b0, 32'h0000_0000);
    chk("status_rst", rd, 32'h0000_0204);
    // program every register of every function
    for (int f = 0; f < 4; f++) begin
      for (int i = 0; i < 8; i++) begin
        cfg[f][i] = pat(f, i);
        apb(12'(f * 64 + i * 4), 1'b1, cfg[f][i]);
      end
      e_bus[8*f +: 8] = cfg[f][0][7:0];   e_dev[5*f +: 5] = cfg[f][0][12:8];
      e_mem[f] = cfg[f][1][1];            e_mst[f] = cfg[f][1][2];   e_vfm[f] = cfg[f][2][3];
      e_vfc[16*f +: 16] = cfg[f][3][15:0]; e_wt[f] = cfg[f][4][8];   e_cpl[f] = cfg[f][5][4];
      e_at[f] = cfg[f][5][6];             e_st[2*f +: 2] = cfg[f][6][1:0]; e_hen[f] = cfg[f][6][8];
      e_stu[5*f +: 5] = cfg[f][7][4:0];   e_xen[f] = cfg[f][7][15];
    end
    repeat (4) @(posedge clock);
    chk("bus", func_bus_number, e_bus);
    chk("dev", func_device_number, e_dev);
    chk("mem", pf_memory_decode_on, e_mem);
    chk("master", pf_requester_allowed, e_mst);
    chk("vf_mem", vf_memory_decode_on, e_vfm);
    chk("vf_count", pf_vf_count, e_vfc);
    chk("wide_tag", pf_wide_tag_on, e_wt);
    chk("cpl_off", pf_cpl_timer_off, e_cpl);
    chk("atomic", pf_atomic_issue_on, e_at);
    chk("st_mode", pf_steering_tag_mode, e_st);
    chk("hint_en", pf_hint_requester_on, e_hen);
    chk("stu", pf_translation_unit_size, e_stu);
    chk("xlate_en", pf_translation_service_on, e_xen);
    for (int f = 0; f < 4; f++) begin
      apb(12'(f * 64), 1'b0, 32'h0000_0000);
      chk("route_rd", rd, {19'h0, cfg[f][0][12:0]});
      chk("route_err", er, 1'b0);
    end
    // limits over 1..4 present functions, then illegal counts ignored
    for (int n = 1; n < 7; n++) begin
      apb(`CSE_ADDR_FUNC_PRESENT, 1'b1, (n > 4) ? ((n == 5) ? 32'h0000_0000 : 32'h0000_0009) : 32'(n));
      pm = 3'h7;
      rm = 3'h7;
      for (int f = 0; f < ((n > 4) ? 4 : n); f++) begin
        if (cfg[f][4][7:5] < pm) pm = cfg[f][4][7:5];
        if (cfg[f][4][14:12] < rm) rm = cfg[f][4][14:12];
      end
      repeat (4) @(posedge clock);
      chk("payload_lim", link_payload_limit, pm);
      chk("rdreq_lim", link_read_request_limit, rm);
    end
    // refused accesses leave every field alone
    for (int k = 0; k < 4; k++) begin
      apb(bad_a[k], k != 0, 32'hffff_ffff);
      chk("bad_err", er, 1'b1);
      if (k == 0) chk("bad_rd", rd, 32'h0000_0000);
    end
    repeat (4) @(posedge clock);
    chk("bus_kept", func_bus_number, e_bus);
    chk("stu_kept", pf_translation_unit_size, e_stu);
    // application builds ids with and without ari
    for (int a = 0; a < 2; a++) begin
      for (int s = 0; s < 4; s++) begin
        ari_on <= 1'(a);
        sel_func <= 2'(s);
        @(posedge clock);
        @(posedge clock);
        chk("req_id", req_id, a ? {cfg[s][0][7:0], 8'(s)} : {cfg[s][0][7:0], cfg[s][0][12:8], 3'(s)});
        chk("req_ok", req_ok, cfg[s][1][2]);
      end
    end
    // reset in mid-run clears every export except the read request limit, which returns to code 2
    reset_n <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    chk("vf_count_rst", pf_vf_count, 64'h0);
    chk("rd_limit_rst2", link_read_request_limit, 3'h2);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk("bus_rst2", func_bus_number, 32'h0000_0000);
    apb(`CSE_ADDR_STATUS, 1'b0, 32'h0000_0000);
    chk("status_rst2", rd, 32'h0000_0204);
    chk("status_err2", er, 1'b0);
    print_verdict();
  end
endmodule
